// file: design/dsb_pkg.sv
// shared constants and types for the two-word burst separate-io sram link
package dsb_pkg;

  // data path geometry
  localparam int WORD_W    = 18;            // one burst word
  localparam int LOC_W     = 36;            // one location, two words
  localparam int ADDR_W    = 19;            // location address
  localparam int LANE_W    = 9;             // one byte lane
  localparam int LANES     = 4;             // lanes per location
  localparam int WORD_LANES = 2;            // lanes per word

  // clock and timing figures
  localparam int CLK_MHZ        = 200;      // system clock rate
  localparam int CLK_PERIOD_NS  = 5;        // system clock period
  localparam int PLL_LOCK_US    = 20;       // stable clock before lock
  localparam int CLK_STOP_NS    = 30;       // stall that resets the pll
  localparam int IMP_PERIOD_CYC = 1024;     // impedance update cadence

  // derived cycle counts
  localparam int LOCK_CNT_W = 12;
  localparam logic [LOCK_CNT_W-1:0] PLL_LOCK_CYC = LOCK_CNT_W'(PLL_LOCK_US * CLK_MHZ);
  localparam int STOP_CNT_W = 3;
  localparam logic [STOP_CNT_W-1:0] CLK_STOP_CYC =
    STOP_CNT_W'((CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int IMP_CNT_W = 10;
  localparam logic [IMP_CNT_W-1:0] IMP_LAST = IMP_CNT_W'(IMP_PERIOD_CYC - 1);

  // host request buffer depth
  localparam int FIFO_DEPTH = 32;

  // pll tracking states
  typedef enum logic [1:0] {
    PLL_OFF     = 2'h0,
    PLL_LOCKING = 2'h1,
    PLL_LOCKED  = 2'h2
  } dsb_pll_t;

  // one queued host request
  typedef struct packed {
    logic                 write;            // 1 write, 0 read
    logic [ADDR_W-1:0]    addr;             // location address
    logic [LANES-1:0]     lane_n;           // lane write selects, low active
    logic [LOC_W-1:0]     data;             // word0 in low half
  } dsb_req_t;

endpackage : dsb_pkg

// file: design/dsb_if.sv
// link between host memory controller and sram device
`timescale 1ns/100ps
`default_nettype none

interface dsb_if
  import dsb_pkg::*;
(
  input wire logic clk_i
);
  logic                    load_strobe_n;         // access strobe, low active
  logic                    rw_sel;                // 1 read, 0 write
  logic [ADDR_W-1:0]       addr;                  // shared address bus
  logic [WORD_W-1:0]       d_rise;                // write word, rising phase
  logic [WORD_W-1:0]       d_fall;                // write word, falling phase
  logic [WORD_LANES-1:0]   byte_lane_write_n_rise; // lane selects with d_rise
  logic [WORD_LANES-1:0]   byte_lane_write_n_fall; // lane selects with d_fall
  logic                    pll_bypass_n;          // low turns the pll off
  logic                    clk_run;               // input clock running
  logic                    out_clk_p;             // output clock, positive
  logic                    out_clk_n;             // output clock, negative
  logic [WORD_W-1:0]       q_rise;                // read word, rising phase
  logic [WORD_W-1:0]       q_fall;                // read word, falling phase
  logic                    q_oe_rise;             // q_rise driven
  logic                    q_oe_fall;             // q_fall driven
  logic                    echo_clock;            // echo of positive phase
  logic                    echo_clock_n;          // echo of negative phase

  // device end
  modport dev (
    input  load_strobe_n, rw_sel, addr, d_rise, d_fall,
    input  byte_lane_write_n_rise, byte_lane_write_n_fall,
    input  pll_bypass_n, clk_run, out_clk_p, out_clk_n,
    output q_rise, q_fall, q_oe_rise, q_oe_fall, echo_clock, echo_clock_n
  );

  // host end
  modport host (
    output load_strobe_n, rw_sel, addr, d_rise, d_fall,
    output byte_lane_write_n_rise, byte_lane_write_n_fall,
    output pll_bypass_n, clk_run, out_clk_p, out_clk_n,
    input  q_rise, q_fall, q_oe_rise, q_oe_fall, echo_clock, echo_clock_n
  );
endinterface : dsb_if

`default_nettype wire

// file: design/dsb_fifo.sv
// parameterised valid/ready fifo with registered flags
`timescale 1ns/100ps
`default_nettype none

module dsb_fifo #(
  parameter int WIDTH = 8,                   // word width
  parameter int DEPTH = 32                   // entries, power of two
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];             // storage
  logic [PTR_W-1:0] wr_ptr_ff;               // next slot to fill
  logic [PTR_W-1:0] rd_ptr_ff;               // oldest slot
  logic [CNT_W-1:0] cnt_ff;                  // words held
  logic [CNT_W-1:0] nxt_cnt;
  logic             in_rdy_ff;               // not full
  logic             out_vld_ff;              // not empty
  logic             push;
  logic             pop;

  assign push        = in_valid_i & in_rdy_ff;
  assign pop         = out_vld_ff & out_ready_i;
  assign nxt_cnt     = cnt_ff + CNT_W'(push) - CNT_W'(pop);
  assign in_ready_o  = in_rdy_ff;
  assign out_valid_o = out_vld_ff;
  assign out_data_o  = mem[rd_ptr_ff];

  // storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data_i;
  end

  // pointers, count and flags
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      cnt_ff     <= '0;
      in_rdy_ff  <= 1'h1;
      out_vld_ff <= 1'h0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
      cnt_ff     <= nxt_cnt;
      in_rdy_ff  <= nxt_cnt != CNT_W'(DEPTH);
      out_vld_ff <= nxt_cnt != '0;
    end
  end

endmodule : dsb_fifo

`default_nettype wire

// file: design/dsb_dev.sv
// sram device end: burst array, posted writes, read latency, pll and echo clocks
`timescale 1ns/100ps
`default_nettype none

module dsb_dev
  import dsb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  dsb_if.dev        link,
  output logic      pll_locked_o,            // pll locked
  output logic      single_clock_o,          // strap seen at reset
  output logic      imp_update_o             // impedance update pulse
);

  // pll tracking
  dsb_pll_t                pll_ff;           // current pll state
  dsb_pll_t                nxt_pll;
  logic [LOCK_CNT_W-1:0]   lock_cnt_ff;      // stable clock cycles
  logic [STOP_CNT_W-1:0]   stop_cnt_ff;      // stalled clock cycles
  logic                    stalled;          // stall long enough
  logic                    ready;            // accesses accepted
  logic                    legacy;           // one cycle latency mode

  // request decode
  logic                    req_rd;
  logic                    req_wr;

  // write capture and posting
  logic                    wstage_ff;        // data due this cycle
  logic [ADDR_W-1:0]       waddr_ff;         // write address register
  logic                    pend_ff;          // posted write held
  logic [ADDR_W-1:0]       paddr_ff;         // posted address
  logic [LOC_W-1:0]        pdata_ff;         // posted data
  logic [LANES-1:0]        pen_ff;           // posted lane enables
  logic [LOC_W-1:0]        din;              // incoming location data
  logic [LANES-1:0]        din_en;           // incoming lane enables
  logic [LOC_W-1:0]        rd_loc;           // read location, forwarded

  // output side
  logic [WORD_W-1:0]       q_rise_ff;
  logic [WORD_W-1:0]       q_fall_ff;
  logic                    oe_rise_ff;
  logic                    oe_fall_ff;
  logic [WORD_W-1:0]       hi_ff;            // second word awaiting rise
  logic                    hi_vld_ff;
  logic                    strap_ff;         // single clock strap
  logic                    echo_ff;
  logic                    echo_n_ff;
  logic [IMP_CNT_W-1:0]    imp_cnt_ff;
  logic                    imp_upd_ff;
  logic                    locked_ff;

  assign stalled = stop_cnt_ff == CLK_STOP_CYC;
  assign ready   = pll_ff != PLL_LOCKING;
  assign legacy  = pll_ff == PLL_OFF;

  // strobe high or pll not ready: nothing starts
  assign req_rd = ready & ~link.load_strobe_n & link.rw_sel;
  assign req_wr = ready & ~link.load_strobe_n & ~link.rw_sel;

  // incoming words: word0 on rising phase is the low half
  assign din    = {link.d_fall, link.d_rise};
  assign din_en = ~{link.byte_lane_write_n_fall,
                    link.byte_lane_write_n_rise};

  // pll state selection
  always_comb
  begin
    nxt_pll = pll_ff;
    case (pll_ff)
      PLL_OFF:
        if (link.pll_bypass_n)
          nxt_pll = PLL_LOCKING;
      PLL_LOCKING:
        if (!link.pll_bypass_n)
          nxt_pll = PLL_OFF;
        else if (!stalled && lock_cnt_ff == PLL_LOCK_CYC - LOCK_CNT_W'(1))
          nxt_pll = PLL_LOCKED;
      PLL_LOCKED:
        if (!link.pll_bypass_n)
          nxt_pll = PLL_OFF;
        else if (stalled)
          nxt_pll = PLL_LOCKING;
      default:
        nxt_pll = PLL_OFF;
    endcase
  end

  // pll state and lock counting
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pll_ff      <= PLL_LOCKING;
      lock_cnt_ff <= '0;
      locked_ff   <= 1'h0;
    end
    else
    begin
      pll_ff <= nxt_pll;
      // count only stable clock while locking
      if (nxt_pll == PLL_LOCKING && pll_ff == PLL_LOCKING && !stalled)
        lock_cnt_ff <= lock_cnt_ff + LOCK_CNT_W'(1);
      else
        lock_cnt_ff <= '0;
      locked_ff <= nxt_pll == PLL_LOCKED;
    end
  end

  // stalled input clock detector, saturating
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      stop_cnt_ff <= '0;
    else if (link.clk_run)
      stop_cnt_ff <= '0;
    else if (!stalled)
      stop_cnt_ff <= stop_cnt_ff + STOP_CNT_W'(1);
  end

  // write address register, data follows next cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wstage_ff <= 1'h0;
      waddr_ff  <= '0;
    end
    else
    begin
      wstage_ff <= req_wr;
      if (req_wr)
        waddr_ff <= link.addr;
    end
  end

  // posted write: held until the next write's data replaces it
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pend_ff  <= 1'h0;
      paddr_ff <= '0;
      pdata_ff <= '0;
      pen_ff   <= '0;
    end
    else if (wstage_ff)
    begin
      pend_ff  <= 1'h1;
      paddr_ff <= waddr_ff;
      pdata_ff <= din;
      pen_ff   <= din_en;
    end
  end

  // one array per lane, committed from the posted register
  genvar g;
  for (g = 0; g < LANES; g++)
  begin : g_lane
    logic [LANE_W-1:0] mem [2**ADDR_W];                        // lane storage
    // commit only when a newer write takes the post slot
    always_ff @(posedge clk_i)
    begin
      if (wstage_ff && pend_ff && pen_ff[g])
        mem[paddr_ff] <= pdata_ff[g*LANE_W +: LANE_W];
    end
    // newest data wins: incoming, then posted, then array
    always_comb
    begin
      if (wstage_ff && waddr_ff == link.addr && din_en[g])
        rd_loc[g*LANE_W +: LANE_W] = din[g*LANE_W +: LANE_W];
      else if (pend_ff && paddr_ff == link.addr && pen_ff[g])
        rd_loc[g*LANE_W +: LANE_W] = pdata_ff[g*LANE_W +: LANE_W];
      else
        rd_loc[g*LANE_W +: LANE_W] = mem[link.addr];
    end
  end

  // read output registers and latency
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q_rise_ff  <= '0;
      q_fall_ff  <= '0;
      oe_rise_ff <= 1'h0;
      oe_fall_ff <= 1'h0;
      hi_ff      <= '0;
      hi_vld_ff  <= 1'h0;
    end
    else if (legacy)
    begin
      // both words in the next cycle
      q_rise_ff  <= rd_loc[WORD_W-1:0];
      q_fall_ff  <= rd_loc[LOC_W-1:WORD_W];
      oe_rise_ff <= req_rd;
      oe_fall_ff <= req_rd;
      hi_vld_ff  <= 1'h0;
    end
    else
    begin
      // word0 on negative phase, word1 on the next rise
      q_fall_ff  <= rd_loc[WORD_W-1:0];
      oe_fall_ff <= req_rd;
      hi_ff      <= rd_loc[LOC_W-1:WORD_W];
      hi_vld_ff  <= req_rd;
      q_rise_ff  <= hi_ff;
      oe_rise_ff <= hi_vld_ff;
    end
  end

  // single clock strap caught while reset is held
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      strap_ff <= link.out_clk_p & link.out_clk_n;
  end

  // echo clocks from output clocks, or from input clock in single clock mode
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      echo_ff   <= 1'h0;
      echo_n_ff <= 1'h1;
    end
    else if (strap_ff)
    begin
      echo_ff   <= ~echo_ff;
      echo_n_ff <= echo_ff;
    end
    else
    begin
      echo_ff   <= link.out_clk_p;
      echo_n_ff <= link.out_clk_n;
    end
  end

  // impedance update cadence
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      imp_cnt_ff <= '0;
      imp_upd_ff <= 1'h0;
    end
    else
    begin
      imp_cnt_ff <= (imp_cnt_ff == IMP_LAST) ? '0 : imp_cnt_ff + IMP_CNT_W'(1);
      imp_upd_ff <= imp_cnt_ff == IMP_LAST;
    end
  end

  // link and status outputs
  assign link.q_rise       = q_rise_ff;
  assign link.q_fall       = q_fall_ff;
  assign link.q_oe_rise    = oe_rise_ff;
  assign link.q_oe_fall    = oe_fall_ff;
  assign link.echo_clock   = echo_ff;
  assign link.echo_clock_n = echo_n_ff;
  assign pll_locked_o      = locked_ff;
  assign single_clock_o    = strap_ff;
  assign imp_update_o      = imp_upd_ff;

endmodule : dsb_dev

`default_nettype wire

// file: design/dsb_host.sv
// host controller end: request queue, link driving and read word pairing
`timescale 1ns/100ps
`default_nettype none

module dsb_host
  import dsb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  dsb_if.host                    link,
  input  wire logic              req_valid_i,     // request offered
  output logic                   req_ready_o,     // queue has room
  input  wire logic              req_write_i,     // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr_i,      // location address
  input  wire logic [LANES-1:0]  req_lane_n_i,    // lane selects, low active
  input  wire logic [LOC_W-1:0]  req_data_i,      // write data, word0 low
  input  wire logic              pll_enable_i,    // run device pll
  input  wire logic              single_clock_i,  // strap single clock mode
  output logic                   link_ready_o,    // issuing allowed
  output logic                   rd_valid_o,      // read location pulse
  output logic [LOC_W-1:0]       rd_data_o        // read location, word0 low
);

  dsb_req_t                in_req;
  dsb_req_t                head;             // oldest queued request
  logic                    head_vld;
  logic                    pop;
  logic [LOCK_CNT_W-1:0]   wait_cnt_ff;      // lock wait counter
  logic                    go_ff;            // device ready for access
  logic                    bypass_n_ff;
  logic                    ld_n_ff;
  logic                    rw_ff;
  logic [ADDR_W-1:0]       addr_ff;
  logic                    wd_vld_ff;        // write data due next cycle
  logic [LOC_W-1:0]        wd_ff;
  logic [LANES-1:0]        wl_ff;
  logic [WORD_W-1:0]       d_rise_ff;
  logic [WORD_W-1:0]       d_fall_ff;
  logic [WORD_LANES-1:0]   bw_rise_ff;
  logic [WORD_LANES-1:0]   bw_fall_ff;
  logic                    oclk_p_ff;
  logic                    oclk_n_ff;
  logic [WORD_W-1:0]       held_ff;          // first word of a pair
  logic                    have_ff;
  logic                    rd_vld_ff;
  logic [LOC_W-1:0]        rd_data_ff;

  assign in_req = '{write: req_write_i, addr: req_addr_i, lane_n: req_lane_n_i, data: req_data_i};
  assign pop    = head_vld & go_ff;

  // request queue, drained one per cycle
  dsb_fifo #(
    .WIDTH ($bits(dsb_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (in_req),
    .out_valid_o (head_vld),
    .out_ready_i (go_ff),
    .out_data_o  (head)
  );

  // pll control and lock wait
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      bypass_n_ff <= 1'h0;
      wait_cnt_ff <= '0;
      go_ff       <= 1'h0;
    end
    else
    begin
      bypass_n_ff <= pll_enable_i;
      if (!bypass_n_ff)
        wait_cnt_ff <= '0;
      else if (wait_cnt_ff != PLL_LOCK_CYC)
        wait_cnt_ff <= wait_cnt_ff + LOCK_CNT_W'(1);
      go_ff <= ~bypass_n_ff | (wait_cnt_ff == PLL_LOCK_CYC);
    end
  end

  // request phase: one strobe per cycle at most
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ld_n_ff   <= 1'h1;
      rw_ff     <= 1'h1;
      addr_ff   <= '0;
      wd_vld_ff <= 1'h0;
      wd_ff     <= '0;
      wl_ff     <= '1;
    end
    else
    begin
      ld_n_ff   <= ~pop;
      if (pop)
      begin
        rw_ff   <= ~head.write;
        addr_ff <= head.addr;
        wd_ff   <= head.data;
        wl_ff   <= head.lane_n;
      end
      wd_vld_ff <= pop & head.write;
    end
  end

  // data phase: word0 rising, word1 falling, the cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      d_rise_ff  <= '0;
      d_fall_ff  <= '0;
      bw_rise_ff <= '1;
      bw_fall_ff <= '1;
    end
    else
    begin
      d_rise_ff  <= wd_ff[WORD_W-1:0];
      d_fall_ff  <= wd_ff[LOC_W-1:WORD_W];
      bw_rise_ff <= wd_vld_ff ? wl_ff[WORD_LANES-1:0] : '1;
      bw_fall_ff <= wd_vld_ff ? wl_ff[LANES-1:WORD_LANES] : '1;
    end
  end

  // output clocks, held high for single clock strap
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || single_clock_i)
    begin
      oclk_p_ff <= single_clock_i;
      oclk_n_ff <= 1'h1;
    end
    else
    begin
      oclk_p_ff <= ~oclk_p_ff;
      oclk_n_ff <= oclk_p_ff;
    end
  end

  // pair returned words in arrival order, rising phase first
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      held_ff    <= '0;
      have_ff    <= 1'h0;
      rd_vld_ff  <= 1'h0;
      rd_data_ff <= '0;
    end
    else if (link.q_oe_rise && link.q_oe_fall)
    begin
      rd_vld_ff  <= 1'h1;
      rd_data_ff <= have_ff ? {link.q_rise, held_ff} : {link.q_fall, link.q_rise};
      held_ff    <= link.q_fall;
    end
    else if (link.q_oe_rise || link.q_oe_fall)
    begin
      held_ff    <= link.q_oe_rise ? link.q_rise : link.q_fall;
      rd_data_ff <= {link.q_oe_rise ? link.q_rise : link.q_fall, held_ff};
      rd_vld_ff  <= have_ff;
      have_ff    <= ~have_ff;
    end
    else
      rd_vld_ff  <= 1'h0;
  end

  assign link.load_strobe_n          = ld_n_ff;
  assign link.rw_sel                 = rw_ff;
  assign link.addr                   = addr_ff;
  assign link.d_rise                 = d_rise_ff;
  assign link.d_fall                 = d_fall_ff;
  assign link.byte_lane_write_n_rise = bw_rise_ff;
  assign link.byte_lane_write_n_fall = bw_fall_ff;
  assign link.pll_bypass_n           = bypass_n_ff;
  assign link.clk_run                = 1'h1;
  assign link.out_clk_p              = oclk_p_ff;
  assign link.out_clk_n              = oclk_n_ff;
  assign link_ready_o                = go_ff;
  assign rd_valid_o                  = rd_vld_ff;
  assign rd_data_o                   = rd_data_ff;

endmodule : dsb_host

`default_nettype wire

// file: verification/dsb_monitor.sv
// link checker for the burst sram link
`timescale 1ns/100ps
`default_nettype none
module dsb_monitor (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_strobe_n,
  input wire logic rw_sel,
  input wire logic pll_bypass_n,
  input wire logic q_oe_rise,
  input wire logic q_oe_fall,
  input wire logic echo_clock,
  input wire logic echo_clock_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // read request seen on the link
  wire rd = !load_strobe_n && rw_sel;
  property p_rst_float; disable iff (1'h0) sys_rst_i |=> !q_oe_rise && !q_oe_fall; endproperty
  a_rst_float: assert property (p_rst_float) else $error("outputs driven after reset");
  property p_legacy; rd && !pll_bypass_n |=> q_oe_rise && q_oe_fall; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy read late");
  property p_b2b; (rd && !pll_bypass_n) [*2] |-> q_oe_rise [*2]; endproperty
  a_b2b: assert property (p_b2b) else $error("back to back read gap");
  property p_pll; rd && pll_bypass_n |=> q_oe_fall ##1 q_oe_rise; endproperty
  a_pll: assert property (p_pll) else $error("pll read words misplaced");
  property p_idle; load_strobe_n [*2] |=> !q_oe_rise && !q_oe_fall; endproperty
  a_idle: assert property (p_idle) else $error("outputs not floated");
  property p_cause; q_oe_fall |-> $past(rd); endproperty
  a_cause: assert property (p_cause) else $error("word without read");
  property p_wr; !load_strobe_n && !rw_sel && !$past(rd) |=> !q_oe_rise; endproperty
  a_wr: assert property (p_wr) else $error("write drove read bus");
  property p_echo; !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> echo_clock != $past(echo_clock); endproperty
  a_echo: assert property (p_echo) else $error("echo clock stalled");
  property p_echo_n; !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> echo_clock_n == $past(echo_clock); endproperty
  a_echo_n: assert property (p_echo_n) else $error("echo pair skewed");
  // main traffic seen
  c_read: cover property (rd);
  c_write: cover property (!load_strobe_n && !rw_sel);
  c_b2b: cover property (rd [*2]);
endmodule : dsb_monitor
`default_nettype wire

// file: verification/tb.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dsb_pkg::*;
  logic clk_i, sys_rst_i, req_valid, req_write, req_ready, link_ready, rd_valid;
  logic pll_en, single_clk, pll_locked, single_clock, imp_update;
  logic [ADDR_W-1:0] req_addr;
  logic [LANES-1:0]  req_lane_n;
  logic [LOC_W-1:0]  req_data, rd_data;
  logic [LOC_W-1:0]  mem [int];   // expected array contents
  logic [LOC_W-1:0]  exp_q [$];   // expected read results
  int bad_count, total_checks;
  initial
  begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  dsb_if u_dsb_if (.clk_i(clk_i));
  dsb_host u_dsb_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(u_dsb_if), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_write_i(req_write), .req_addr_i(req_addr), .req_lane_n_i(req_lane_n),
    .req_data_i(req_data), .pll_enable_i(pll_en), .single_clock_i(single_clk), .link_ready_o(link_ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  dsb_dev u_dsb_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(u_dsb_if), .pll_locked_o(pll_locked),
    .single_clock_o(single_clock), .imp_update_o(imp_update));
  dsb_monitor u_dsb_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_strobe_n(u_dsb_if.load_strobe_n),
    .rw_sel(u_dsb_if.rw_sel), .pll_bypass_n(u_dsb_if.pll_bypass_n), .q_oe_rise(u_dsb_if.q_oe_rise),
    .q_oe_fall(u_dsb_if.q_oe_fall), .echo_clock(u_dsb_if.echo_clock), .echo_clock_n(u_dsb_if.echo_clock_n));
  task automatic fail(input string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  // offer one request, update the expected model once taken
  task automatic push(input logic w, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] l,
                      input logic [LOC_W-1:0] d);
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_lane_n = l;
    req_data = d;
    while (req_ready !== 1'h1) begin @(posedge clk_i); #1; end
    @(posedge clk_i);
    #1;
    if (w)
    begin
      for (int i = 0; i < LANES; i++) if (!l[i]) mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    end
    else
      exp_q.push_back(mem[a]);
  endtask : push
  // stop offering and wait for every read to come back
  task automatic drain(input string n);
    req_valid = 1'h0;
    repeat (100) if (exp_q.size() != 0) @(posedge clk_i);
    total_checks++;
    if (exp_q.size() != 0) fail("read lost");
    $display("test %s done", n);
    @(posedge clk_i);
    #1;
  endtask : drain
  // compare each returned location in order, mid-cycle where it is settled
  always @(negedge clk_i)
    if (rd_valid === 1'h1)
    begin
      total_checks++;
      if (exp_q.size() == 0 || rd_data !== exp_q[0]) fail("read data");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  task automatic t_basic;
    push(1'h1, 19'h5, 4'h0, 36'h9_A5C3_1E7B);
    push(1'h0, 19'h5, 4'hF, 36'h0);
    drain("basic");
  endtask : t_basic
  task automatic t_lanes;
    push(1'h1, 19'h5, 4'hA, 36'h1_2345_6789);
    push(1'h0, 19'h5, 4'hF, 36'h0);
    push(1'h1, 19'h5, 4'h5, 36'hE_DCBA_9876);
    push(1'h1, 19'h5, 4'hF, 36'hF_FFFF_FFFF);
    push(1'h0, 19'h5, 4'hF, 36'h0);
    drain("lanes");
  endtask : t_lanes
  task automatic t_stream;
    for (int i = 0; i < 8; i++) push(1'h1, ADDR_W'(i + 16), 4'h0, 36'hF_0F0F_0000 | LOC_W'(i));
    for (int i = 0; i < 8; i++) push(1'h0, ADDR_W'(i + 16), 4'hF, 36'h0);
    push(1'h1, 19'h40, 4'h0, 36'h3_3333_3333);
    for (int i = 0; i < 8; i++) push(1'h0, ADDR_W'(i + 16), 4'hF, 36'h0);
    drain("stream");
  endtask : t_stream
  // mid-run reset into pll mode with the single clock strap, then pll-latency reads
  task automatic t_modes;
    int n;
    sys_rst_i = 1'h1;
    pll_en = 1'h1;
    single_clk = 1'h1;
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 1'h0;
    repeat (PLL_LOCK_US * CLK_MHZ - 10) @(posedge clk_i);
    #1;
    total_checks++;
    if (pll_locked !== 1'h0) fail("pll locked too early");
    repeat (100) if (link_ready !== 1'h1) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    total_checks++;
    if (pll_locked !== 1'h1) fail("pll not locked");
    total_checks++;
    if (single_clock !== 1'h1) fail("strap not seen");
    while (imp_update !== 1'h1) begin @(posedge clk_i); #1; end
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (imp_update !== 1'h1 && n < 2 * IMP_PERIOD_CYC);
    total_checks++;
    if (n != IMP_PERIOD_CYC) fail("impedance cadence");
    push(1'h1, 19'h100, 4'h0, 36'h5_0000_A5A5);
    push(1'h1, 19'h101, 4'h0, 36'hC_3C3C_0001);
    push(1'h0, 19'h100, 4'hF, 36'h0);
    push(1'h0, 19'h101, 4'hF, 36'h0);
    push(1'h0, 19'h100, 4'hF, 36'h0);
    drain("modes");
  endtask : t_modes
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    sys_rst_i = 1'h1;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = '0;
    req_lane_n = '1;
    req_data = '0;
    pll_en = 1'h0;
    single_clk = 1'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 1'h0;
    repeat (20) if (link_ready !== 1'h1) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    t_basic;
    t_lanes;
    t_stream;
    t_modes;
    final_report;
  end
  // hang guard, about twice the pll lock wait, cadence check and traffic
  initial
  begin
    #60000;
    fail("timeout");
    final_report;
  end
endmodule : tb
`default_nettype wire
